//--- pcipm_pkg.sv
package pcipm_pkg;

	// Configuration space offsets (byte addresses)
	localparam logic [7:0] PCIPM_OFF_CAP_PTR    = 8'h34;
	localparam logic [7:0] PCIPM_OFF_PM_CAP     = 8'h50;

	// Fixed field values
	localparam logic [7:0] PCIPM_CAP_ID         = 8'h01;
	localparam logic [7:0] PCIPM_NEXT_PTR       = 8'h00;
	localparam logic [7:0] PCIPM_CAP_PTR_VAL    = 8'h50;
	localparam logic       PCIPM_WAKE_CLK       = 1'h0;
	localparam logic       PCIPM_RSVD20         = 1'h0;

	// Reset defaults of loadable fields
	localparam logic [4:0] PCIPM_WAKE_DEF       = 5'h18;
	localparam logic [1:0] PCIPM_D1D2_DEF       = 2'h0;
	localparam logic [2:0] PCIPM_AUX_DEF        = 3'h3;
	localparam logic       PCIPM_DSI_DEF        = 1'h1;
	localparam logic [2:0] PCIPM_VER_DEF        = 3'h2;

	// EEPROM word indices
	localparam logic [7:0] PCIPM_EE_WORD4       = 8'h04;
	localparam logic [7:0] PCIPM_EE_WORD7       = 8'h07;

	// EEPROM word 7 field positions
	localparam int         PCIPM_EE7_WAKE_HI    = 7;
	localparam int         PCIPM_EE7_WAKE_LO    = 3;
	localparam int         PCIPM_EE7_DSI        = 2;
	localparam int         PCIPM_EE7_D1D2_HI    = 1;
	localparam int         PCIPM_EE7_D1D2_LO    = 0;

	// EEPROM word 4 field positions
	localparam int         PCIPM_EE4_AUX_HI     = 15;
	localparam int         PCIPM_EE4_AUX_LO     = 13;
	localparam int         PCIPM_EE4_VER_HI     = 12;
	localparam int         PCIPM_EE4_VER_LO     = 10;
	localparam int         PCIPM_EE4_LOAD_EN    = 9;

	// Read answer for any other offset
	localparam logic [31:0] PCIPM_UNMAPPED      = 32'h0000_0000;

endpackage

//--- pcipm_field.sv
// Reloadable read-only field: reset default, replaced on a load strobe
module pcipm_field
	import pcipm_pkg::*;
#(
	parameter int         W   = 1,
	parameter logic [W-1:0] DEF = '0
)
(
	// Clock and reset
	input  wire logic         i_clk_sys,
	input  wire logic         i_rst,
	// Load
	input  wire logic         i_load,
	input  wire logic [W-1:0] i_value,
	// Field
	output logic      [W-1:0] o_value
);

	logic [W-1:0] value_reg;
	logic [W-1:0] value_next;

	always_comb
	begin
		value_next = value_reg;
		if (i_load)
		begin
			value_next = i_value;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			value_reg <= DEF;
		end
		else
		begin
			value_reg <= value_next;
		end
	end

	assign o_value = value_reg;

endmodule

//--- pcipm_rdreg.sv
// Registered read data for the configuration read port
module pcipm_rdreg
	import pcipm_pkg::*;
(
	// Clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst,
	// Read request
	input  wire logic        i_rd,
	input  wire logic [31:0] i_data,
	// Read answer
	output logic      [31:0] o_data,
	output logic             o_valid
);

	logic [31:0] data_reg;
	logic [31:0] data_next;
	logic        valid_reg;
	logic        valid_next;

	always_comb
	begin
		data_next  = data_reg;
		valid_next = i_rd;
		if (i_rd)
		begin
			data_next = i_data;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			data_reg  <= PCIPM_UNMAPPED;
			valid_reg <= 1'h0;
		end
		else
		begin
			data_reg  <= data_next;
			valid_reg <= valid_next;
		end
	end

	assign o_data  = data_reg;
	assign o_valid = valid_reg;

endmodule

//--- pcipm_cap.sv
// Operation
// [R01] Capability ID reads 01h
// [R02] Next item pointer reads 00h
// [R03] Bits 31:27 wake support per state
// [R04] Wake support defaults to 11000
// [R05] Wake support loads from EEPROM word 7[7:3]
// [R06] Bits 26:25 read 00, load word 7[1:0]
// [R07] Aux current defaults to 011
// [R08] Aux current loads word 4[15:13] if bit9
// [R09] Init-needed bit defaults 1, word 7[2]
// [R10] Bits 20 and 19 read 0
// [R11] Version defaults to 010
// [R12] Version loads word 4[12:10] if bit9
// [R13] Capability pointer reads 50h
// [R14] Configuration writes are ignored
module pcipm_cap
	import pcipm_pkg::*;
(
	// Clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst,
	// Configuration access
	input  wire logic        i_cfg_rd,
	input  wire logic        i_cfg_wr,
	input  wire logic [7:0]  i_cfg_addr,
	input  wire logic [31:0] i_cfg_wdata,
	output logic      [31:0] o_cfg_rdata,
	output logic             o_cfg_rvalid,
	// EEPROM load
	input  wire logic        i_ee_valid,
	input  wire logic [7:0]  i_ee_addr,
	input  wire logic [15:0] i_ee_data,
	// Field view
	output logic      [4:0]  o_wake_state_support
);

	logic       ld_w7;
	logic       ld_w4;
	logic [4:0] wake_sup;
	logic [1:0] d1d2;
	logic [2:0] aux_cur;
	logic       dsi;
	logic [2:0] version;
	logic [31:0] pm_word;
	logic [31:0] rd_mux;

	// [R05] Word 7 load strobe
	assign ld_w7 = i_ee_valid && (i_ee_addr == PCIPM_EE_WORD7);
	// [R08] Word 4 gated by bit 9
	assign ld_w4 = i_ee_valid && (i_ee_addr == PCIPM_EE_WORD4)
		&& i_ee_data[PCIPM_EE4_LOAD_EN];

	// [R04] Wake support default
	pcipm_field #(.W(5), .DEF(PCIPM_WAKE_DEF)) u_wake (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_load    (ld_w7),
		.i_value   (i_ee_data[PCIPM_EE7_WAKE_HI:PCIPM_EE7_WAKE_LO]),
		.o_value   (wake_sup)
	);

	// [R06] D1/D2 bits load
	pcipm_field #(.W(2), .DEF(PCIPM_D1D2_DEF)) u_d1d2 (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_load    (ld_w7),
		.i_value   (i_ee_data[PCIPM_EE7_D1D2_HI:PCIPM_EE7_D1D2_LO]),
		.o_value   (d1d2)
	);

	// [R07] Aux current default
	pcipm_field #(.W(3), .DEF(PCIPM_AUX_DEF)) u_aux (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_load    (ld_w4),
		.i_value   (i_ee_data[PCIPM_EE4_AUX_HI:PCIPM_EE4_AUX_LO]),
		.o_value   (aux_cur)
	);

	// [R09] Init-needed bit
	pcipm_field #(.W(1), .DEF(PCIPM_DSI_DEF)) u_dsi (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_load    (ld_w7),
		.i_value   (i_ee_data[PCIPM_EE7_DSI]),
		.o_value   (dsi)
	);

	// [R11] [R12] Version field
	pcipm_field #(.W(3), .DEF(PCIPM_VER_DEF)) u_ver (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_load    (ld_w4),
		.i_value   (i_ee_data[PCIPM_EE4_VER_HI:PCIPM_EE4_VER_LO]),
		.o_value   (version)
	);

	// [R03] [R10] [R02] [R01] Word assembly
	assign pm_word = {wake_sup, d1d2, aux_cur, dsi, PCIPM_RSVD20, PCIPM_WAKE_CLK,
		version, PCIPM_NEXT_PTR, PCIPM_CAP_ID};

	// [R13] Pointer and register decode
	always_comb
	begin
		rd_mux = PCIPM_UNMAPPED;
		if (i_cfg_addr == PCIPM_OFF_PM_CAP)
		begin
			rd_mux = pm_word;
		end
		else if (i_cfg_addr == PCIPM_OFF_CAP_PTR)
		begin
			rd_mux = {24'h00_0000, PCIPM_CAP_PTR_VAL};
		end
	end

	// [R14] Writes have no effect
	pcipm_rdreg u_rd (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_rd      (i_cfg_rd && !i_cfg_wr),
		.i_data    (rd_mux),
		.o_data    (o_cfg_rdata),
		.o_valid   (o_cfg_rvalid)
	);

	assign o_wake_state_support = wake_sup;

endmodule

//--- pcipm_cap_props.sv
module pcipm_cap_chk
(
	// Watched ports
	input wire logic        i_clk_sys,
	input wire logic        i_rst,
	input wire logic        i_cfg_rd,
	input wire logic        i_cfg_wr,
	input wire logic [7:0]  i_cfg_addr,
	input wire logic [31:0] o_cfg_rdata,
	input wire logic        o_cfg_rvalid,
	input wire logic        i_ee_valid,
	input wire logic [7:0]  i_ee_addr,
	input wire logic [15:0] i_ee_data,
	input wire logic [4:0]  o_wake_state_support
);
	wire logic       rd_take = i_cfg_rd & ~i_cfg_wr;
	wire logic       rd_cap  = rd_take && i_cfg_addr == 8'h50;
	wire logic [4:0] ee_wake = i_ee_data[7:3];
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	a_read_answered: assert property (rd_take |=> o_cfg_rvalid) else $error("no answer");
	a_no_extra: assert property (!rd_take |=> !o_cfg_rvalid) else $error("extra valid");
	a_cap_id_next:
		assert property (rd_cap |=> o_cfg_rdata[15:0] == 16'h0001) else $error("bad id");
	a_rsvd_zero:
		assert property (rd_cap |=> o_cfg_rdata[20:19] == 2'h0) else $error("bad 20:19");
	a_wake_mirror:
		assert property (rd_cap |=> o_cfg_rdata[31:27] == $past(o_wake_state_support))
			else $error("bad wake");
	a_cap_pointer:
		assert property (rd_take && i_cfg_addr == 8'h34 |=> o_cfg_rdata == 32'h0000_0050)
			else $error("bad ptr");
	a_write_ignored:
		assert property (i_cfg_wr |=> !o_cfg_rvalid && $stable(o_cfg_rdata))
			else $error("write seen");
	a_word7_load:
		assert property (i_ee_valid && i_ee_addr == 8'h07 |=> o_wake_state_support == $past(ee_wake))
			else $error("no load");
	c_cap_read: cover property (rd_cap);
	c_word4: cover property (i_ee_valid && i_ee_addr == 8'h04);
	c_write: cover property (i_cfg_wr);
endmodule

bind pcipm_cap pcipm_cap_chk u_chk (.*);

//--- pcipm_ee_model.sv
module pcipm_ee_model
(
	input wire logic        i_clk_sys,
	input wire logic        i_go,
	input wire logic [7:0]  i_word,
	input wire logic [15:0] i_data,
	output logic            o_ee_valid,
	output logic     [7:0]  o_ee_addr,
	output logic     [15:0] o_ee_data
);
	timeunit 1ns;
	timeprecision 1ps;
	// Off-strobe word toggles so stale values never look valid
	always @(posedge i_clk_sys)
	begin
		o_ee_valid <= i_go;
		o_ee_addr  <= i_go ? i_word : ~o_ee_addr;
		o_ee_data  <= i_go ? i_data : ~o_ee_data;
	end
	initial o_ee_addr = '0;
	initial o_ee_data = '0;
endmodule

//--- tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
		$display("mismatch %0t got %h exp %h", $time, g, e); end end
	logic        i_clk_sys = 0, i_rst = 1, rd = 0, wr = 0, go = 0, ee_v, rvalid;
	logic [7:0]  addr = 0, word = 0, ee_a;
	logic [15:0] edat = 0, ee_d;
	logic [31:0] wdat = 0, rdata;
	logic [4:0]  wake;
	int          errors = 0, checks = 0;
	always #5 i_clk_sys = ~i_clk_sys;
	pcipm_cap DUT (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_cfg_rd(rd), .i_cfg_wr(wr),
		.i_cfg_addr(addr), .i_cfg_wdata(wdat), .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid),
		.i_ee_valid(ee_v), .i_ee_addr(ee_a), .i_ee_data(ee_d), .o_wake_state_support(wake));
	pcipm_ee_model PEER (.i_clk_sys(i_clk_sys), .i_go(go), .i_word(word), .i_data(edat),
		.o_ee_valid(ee_v), .o_ee_addr(ee_a), .o_ee_data(ee_d));
	task automatic cfg(input logic w, input logic [7:0] a, input logic [31:0] exp);
		@(posedge i_clk_sys);
		rd <= ~w;
		wr <= w;
		addr <= a;
		wdat <= 32'hFFFF_FFFF;
		@(posedge i_clk_sys);
		rd <= 0;
		wr <= 0;
		#1;
		if (!w) `CHK(rdata, exp)
		`CHK(rvalid, ~w)
	endtask
	task automatic ee(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_clk_sys);
		go <= 1;
		word <= a;
		edat <= d;
		@(posedge i_clk_sys);
		go <= 0;
		repeat (2) @(posedge i_clk_sys);
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge i_clk_sys);
		i_rst <= 0;
		cfg(0, 8'h50, 32'hC0E2_0001);
		`CHK(wake, 5'h18)
		cfg(0, 8'h34, 32'h0000_0050);
		cfg(0, 8'h54, 32'h0000_0000);
		cfg(1, 8'h50, 32'h0000_0000);
		cfg(0, 8'h50, 32'hC0E2_0001);
		$display("test defaults done");
		ee(8'h04, 16'hFC00);
		cfg(0, 8'h50, 32'hC0E2_0001);
		ee(8'h04, 16'hAE00);
		cfg(0, 8'h50, 32'hC163_0001);
		ee(8'h07, 16'h00AB);
		cfg(0, 8'h50, 32'hAF43_0001);
		`CHK(wake, 5'h15)
		$display("test eeprom done");
		@(posedge i_clk_sys);
		i_rst <= 1;
		repeat (2) @(posedge i_clk_sys);
		i_rst <= 0;
		cfg(0, 8'h50, 32'hC0E2_0001);
		`CHK(wake, 5'h18)
		$display("test reset done");
		close_out();
	end
	initial
	begin
		repeat (500) @(posedge i_clk_sys);
		errors++;
		close_out();
	end
endmodule
